// ===== src/cor_regs.sv
// Channel output control register bank on AHB-Lite
module cor_regs
    import cor_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // Datapath controls
    output cor_pat_ctrl_t pat_ctrl,
    output cor_ch_ctrl_t ch_ctrl,
    output cor_ch9_ctrl_t ch9_ctrl,
    output logic ch9_offset_mismatch
);

    logic dp_write;
    logic dp_read;
    logic [7:0] dp_index;
    logic [15:0] pattern_reg;
    logic [15:0] pwr_inv_reg;
    logic [15:0] gain_ofs_reg;
    logic [15:0] ofs_mirror_reg;
    logic [15:0] global_reg;
    logic [31:0] rdata_next;

    cor_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .dp_write(dp_write),
        .dp_read(dp_read),
        .dp_index(dp_index)
    );

    cor_reg16 #(.MASK(COR_MASK_PATTERN)) u_pattern (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(dp_write && dp_index == COR_IDX_PATTERN),
        .wr_data(hwdata[15:0]),
        .value(pattern_reg)
    );

    cor_reg16 #(.MASK(COR_MASK_PWR_INV)) u_pwr_inv (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(dp_write && dp_index == COR_IDX_PWR_INV),
        .wr_data(hwdata[15:0]),
        .value(pwr_inv_reg)
    );

    cor_reg16 #(.MASK(COR_MASK_GAIN_OFS)) u_gain_ofs (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(dp_write && dp_index == COR_IDX_GAIN_OFS),
        .wr_data(hwdata[15:0]),
        .value(gain_ofs_reg)
    );

    cor_reg16 #(.MASK(COR_MASK_OFS_MIRROR)) u_ofs_mirror (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(dp_write && dp_index == COR_IDX_OFS_MIRROR),
        .wr_data(hwdata[15:0]),
        .value(ofs_mirror_reg)
    );

    cor_reg16 #(.MASK(COR_MASK_GLOBAL)) u_global (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(dp_write && dp_index == COR_IDX_GLOBAL_CTRL),
        .wr_data(hwdata[15:0]),
        .value(global_reg)
    );

    // Always zero wait, always OKAY; hsize is single word only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= COR_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= COR_HRESP_OKAY;
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (dp_index)
            COR_IDX_PATTERN: rdata_next = {16'h0000, pattern_reg};
            COR_IDX_PWR_INV: rdata_next = {16'h0000, pwr_inv_reg};
            COR_IDX_GAIN_OFS: rdata_next = {16'h0000, gain_ofs_reg};
            COR_IDX_OFS_MIRROR: rdata_next = {16'h0000, ofs_mirror_reg};
            COR_IDX_GLOBAL_CTRL: rdata_next = {16'h0000, global_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data held on hrdata in the data phase cycle
    assign hrdata = dp_read ? rdata_next : 32'h0000_0000;

    // Pattern selection for outputs 7 and 8
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pat_ctrl <= '0;
        end else begin
            pat_ctrl.active <= global_reg[COR_GLB_PATSEL_BIT];
            pat_ctrl.out7_code <= global_reg[COR_GLB_PATSEL_BIT] ?
                pattern_reg[COR_OUT7_PAT_LSB +: COR_PAT_W] : 3'h0;
            pat_ctrl.out8_code <= global_reg[COR_GLB_PATSEL_BIT] ?
                pattern_reg[COR_OUT8_PAT_LSB +: COR_PAT_W] : 3'h0;
        end
    end

    // Per-channel power-down and invert for channels 5..8
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch_ctrl <= '0;
        end else begin
            ch_ctrl.dig_powerdown <= pwr_inv_reg[COR_DIG_PDN_LSB +: 4];
            ch_ctrl.line_powerdown <= pwr_inv_reg[COR_LINE_PDN_LSB +: 4];
            ch_ctrl.ana_powerdown <= pwr_inv_reg[COR_ANA_PDN_LSB +: 4];
            ch_ctrl.data_invert <= pwr_inv_reg[COR_INV_LSB +: 4];
        end
    end

    // Channel 9 gain and offset, gated by global enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch9_ctrl <= '0;
        end else begin
            ch9_ctrl.gain_active <= global_reg[COR_GLB_GAIN_BIT];
            ch9_ctrl.gain_code <= global_reg[COR_GLB_GAIN_BIT] ?
                gain_ofs_reg[COR_GAIN_LSB +: COR_GAIN_W] : 5'h00;
            ch9_ctrl.offset_active <= global_reg[COR_GLB_OFS_BIT];
            ch9_ctrl.offset_value <= global_reg[COR_GLB_OFS_BIT] ?
                gain_ofs_reg[COR_OFS_LSB +: COR_OFS_W] : 10'h000;
        end
    end

    // Flags software failing to keep both offset copies equal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch9_offset_mismatch <= 1'b0;
        end else begin
            ch9_offset_mismatch <= gain_ofs_reg[COR_OFS_LSB +: COR_OFS_W] !=
                ofs_mirror_reg[COR_OFS_LSB +: COR_OFS_W];
        end
    end

endmodule

// ===== src/cor_pkg.sv
// Package of register map, field layout and carrier types for output control
package cor_pkg;

    // Register indices (printed offsets; 0x23 is the pattern register)
    localparam logic [7:0] COR_IDX_PATTERN = 8'h23;
    localparam logic [7:0] COR_IDX_PWR_INV = 8'h24;
    localparam logic [7:0] COR_IDX_GAIN_OFS = 8'h25;
    localparam logic [7:0] COR_IDX_OFS_MIRROR = 8'h26;
    localparam logic [7:0] COR_IDX_GLOBAL_CTRL = 8'h30;

    // Reset values
    localparam logic [15:0] COR_RESET_VALUE = 16'h0000;

    // Field positions
    localparam int COR_OUT7_PAT_LSB = 5;
    localparam int COR_OUT8_PAT_LSB = 2;
    localparam int COR_PAT_W = 3;
    localparam int COR_DIG_PDN_LSB = 12;
    localparam int COR_LINE_PDN_LSB = 8;
    localparam int COR_ANA_PDN_LSB = 4;
    localparam int COR_INV_LSB = 0;
    localparam int COR_GAIN_LSB = 11;
    localparam int COR_GAIN_W = 5;
    localparam int COR_OFS_LSB = 0;
    localparam int COR_OFS_W = 10;
    localparam int COR_GLB_PATSEL_BIT = 0;
    localparam int COR_GLB_GAIN_BIT = 1;
    localparam int COR_GLB_OFS_BIT = 2;

    // Writable masks; reserved bits are held at zero
    localparam logic [15:0] COR_MASK_PATTERN = 16'h00FC;
    localparam logic [15:0] COR_MASK_PWR_INV = 16'hFFFF;
    localparam logic [15:0] COR_MASK_GAIN_OFS = 16'hFBFF;
    localparam logic [15:0] COR_MASK_OFS_MIRROR = 16'h03FF;
    localparam logic [15:0] COR_MASK_GLOBAL = 16'h0007;

    // AHB constants
    localparam logic [1:0] COR_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] COR_HTRANS_SEQ = 2'b11;
    localparam logic [1:0] COR_HRESP_OKAY = 2'b00;

    // Per-channel controls for channels/lines 5..8 (index 0 = ch5)
    typedef struct packed {
        logic [3:0] dig_powerdown;
        logic [3:0] line_powerdown;
        logic [3:0] ana_powerdown;
        logic [3:0] data_invert;
    } cor_ch_ctrl_t;

    // Channel 9 datapath settings
    typedef struct packed {
        logic gain_active;
        logic [4:0] gain_code;
        logic offset_active;
        logic signed [9:0] offset_value;
    } cor_ch9_ctrl_t;

    // Serial output 7/8 test pattern selection
    typedef struct packed {
        logic active;
        logic [2:0] out7_code;
        logic [2:0] out8_code;
    } cor_pat_ctrl_t;

endpackage

// ===== src/cor_reg16.sv
// One 16-bit software register with write mask and zero reset
module cor_reg16
    import cor_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // Stored value
    output logic [15:0] value
);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value <= COR_RESET_VALUE;
        end else if (wr_en) begin
            value <= wr_data & MASK;
        end
    end

endmodule

// ===== src/cor_ahb_slave.sv
// AHB-Lite address-phase capture with zero-wait-state answer
module cor_ahb_slave
    import cor_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus address phase
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // Captured data-phase request
    output logic dp_write,
    output logic dp_read,
    output logic [7:0] dp_index
);

    logic take;

    assign take = hsel && hready &&
        (htrans == COR_HTRANS_NONSEQ || htrans == COR_HTRANS_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= 8'h00;
        end else begin
            dp_write <= take && hwrite;
            dp_read <= take && !hwrite;
            if (take) begin
                dp_index <= haddr[9:2];
            end
        end
    end

endmodule

// ===== tb/cor_regs_sva.sv
// Assertion checker for the output control register bank
module cor_regs_sva
    import cor_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Controls
    input wire cor_pat_ctrl_t pat_ctrl,
    input wire cor_ch_ctrl_t ch_ctrl,
    input wire cor_ch9_ctrl_t ch9_ctrl
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_req;
    logic rd_req;
    logic [31:0] wd_q1;
    logic [31:0] wd_q2;
    assign wr_req = hsel && hready && htrans[1] && hwrite;
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    // Write data as seen two edges back
    always_ff @(posedge hclk) begin
        wd_q1 <= hwdata;
        wd_q2 <= wd_q1;
    end
    a_ctrl_write: assert property (
        wr_req && haddr == 32'h0000_0090 |-> ##3 ch_ctrl == wd_q2[15:0])
        else $error("channel controls differ from written word");
    a_out7_code: assert property (
        wr_req && haddr == 32'h0000_008C |-> ##3
        (!pat_ctrl.active || pat_ctrl.out7_code == wd_q2[7:5]))
        else $error("output 7 code differs from written field");
    a_out8_code: assert property (
        wr_req && haddr == 32'h0000_008C |-> ##3
        (!pat_ctrl.active || pat_ctrl.out8_code == wd_q2[4:2]))
        else $error("output 8 code differs from written field");
    a_pat_gated: assert property (
        !pat_ctrl.active |-> {pat_ctrl.out7_code, pat_ctrl.out8_code} == 6'h00)
        else $error("pattern codes active without selection");
    a_gain_write: assert property (
        wr_req && haddr == 32'h0000_0094 |-> ##3
        (!ch9_ctrl.gain_active || ch9_ctrl.gain_code == wd_q2[15:11]))
        else $error("gain code differs from written field");
    a_offset_write: assert property (
        wr_req && haddr == 32'h0000_0094 |-> ##3
        (!ch9_ctrl.offset_active || ch9_ctrl.offset_value == wd_q2[9:0]))
        else $error("offset differs from written field");
    a_gain_gated: assert property (
        !ch9_ctrl.gain_active |-> ch9_ctrl.gain_code == 5'h00)
        else $error("gain code passed while disabled");
    a_unmapped_read: assert property (
        rd_req && haddr == 32'h0000_0100 |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");
    a_pattern_read: assert property (
        rd_req && haddr == 32'h0000_008C |=>
        (hrdata & 32'hFFFF_FF03) == 32'h0000_0000)
        else $error("reserved pattern bits read nonzero");
endmodule

bind cor_regs cor_regs_sva i_cor_regs_sva (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .pat_ctrl, .ch_ctrl,
    .ch9_ctrl);

// ===== tb/test_channel_output_control_regs.sv
// Self-checking testbench for the output control register bank
module test_channel_output_control_regs import cor_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [1:0] hresp;
    logic [31:0] hrdata;
    logic [31:0] rd_q;
    logic rdy_q;
    cor_pat_ctrl_t pat_ctrl;
    cor_ch_ctrl_t ch_ctrl;
    cor_ch9_ctrl_t ch9_ctrl;
    logic ch9_offset_mismatch;
    int bad_count = 0;
    int checked = 0;

    cor_regs i_cor_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .pat_ctrl, .ch_ctrl, .ch9_ctrl, .ch9_offset_mismatch);

    always #10 hclk = ~hclk;
    // Bus values as sampled at each edge
    always @(posedge hclk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
    end

    task give_verdict();
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task step();
        @(posedge hclk);
        #1;
    endtask

    task wait_rdy();
        int n;
        n = 0;
        step();
        while (rdy_q !== 1'b1) begin
            n++;
            if (n > 40) begin
                bad_count++;
                give_verdict();
            end
            step();
        end
    endtask

    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= COR_HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    task rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, e, rd_q);
        chk("hresp", 32'(COR_HRESP_OKAY), 32'(hresp));
        chk("hreadyout", 32'h0000_0001, 32'(hreadyout));
    endtask

    task s_reset();
        logic [31:0] addrs [5];
        addrs = '{32'h0000_008C, 32'h0000_0090, 32'h0000_0094,
            32'h0000_0098, 32'h0000_00C0};
        foreach (addrs[i])
            rd(addrs[i], 32'h0000_0000, "reset");
        chk("ch reset", 32'h0000_0000, 32'(ch_ctrl));
    endtask

    task s_power();
        xfer(32'h0000_0090, 1'b1, 32'hFFFF_A5C3);
        step();
        chk("dig", 32'h0000_000A, 32'(ch_ctrl.dig_powerdown));
        chk("line", 32'h0000_0005, 32'(ch_ctrl.line_powerdown));
        chk("ana", 32'h0000_000C, 32'(ch_ctrl.ana_powerdown));
        chk("inv", 32'h0000_0003, 32'(ch_ctrl.data_invert));
        rd(32'h0000_0090, 32'h0000_A5C3, "pwr back");
    endtask

    task s_pattern();
        xfer(32'h0000_00C0, 1'b1, 32'h0000_0000);
        xfer(32'h0000_008C, 1'b1, 32'h0000_FFA9);
        step();
        chk("pat off", 32'h0000_0000, 32'(pat_ctrl));
        xfer(32'h0000_00C0, 1'b1, 32'h0000_0001);
        step();
        chk("out7", 32'h0000_0005, 32'(pat_ctrl.out7_code));
        chk("out8", 32'h0000_0002, 32'(pat_ctrl.out8_code));
        rd(32'h0000_008C, 32'h0000_00A8, "pat back");
        xfer(32'h0000_008C, 1'b1, 32'h0000_0014);
        step();
        chk("out7 new", 32'h0000_0000, 32'(pat_ctrl.out7_code));
        chk("out8 new", 32'h0000_0005, 32'(pat_ctrl.out8_code));
    endtask

    task s_ch9();
        xfer(32'h0000_00C0, 1'b1, 32'h0000_0006);
        xfer(32'h0000_0094, 1'b1, 32'h0000_FE00);
        xfer(32'h0000_0098, 1'b1, 32'h0000_FE00);
        step();
        chk("gain", 32'h0000_001F, 32'(ch9_ctrl.gain_code));
        chk("ofs", 32'hFFFF_FE00, 32'(ch9_ctrl.offset_value));
        rd(32'h0000_0094, 32'h0000_FA00, "gain back");
        rd(32'h0000_0098, 32'h0000_0200, "mirror back");
        chk("mismatch", 32'h0000_0000, 32'(ch9_offset_mismatch));
        xfer(32'h0000_00C0, 1'b1, 32'h0000_0000);
        step();
        chk("ch9 off", 32'h0000_0000, 32'(ch9_ctrl));
    endtask

    task s_unmapped();
        xfer(32'h0000_0100, 1'b1, 32'h0000_FFFF);
        rd(32'h0000_0100, 32'h0000_0000, "unmapped");
        rd(32'h0000_0090, 32'h0000_A5C3, "pwr kept");
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        step();
        s_reset();
        s_power();
        s_pattern();
        s_ch9();
        s_unmapped();
        give_verdict();
    end
endmodule
